// [inc/slc_map.svh]
// Constants of the link controller: control byte coding and timing.
// Assumes a 250 MHz core clock; times are given in microseconds.
`ifndef SLC_MAP_SVH
`define SLC_MAP_SVH
`define SLC_INFO_TAG 2'h2
`define SLC_SUP_TAG 3'h6
`define SLC_UNN_TAG 3'h7
`define SLC_S_RR 2'h0
`define SLC_S_REJ 2'h1
`define SLC_S_RNR 2'h2
`define SLC_S_SREJ 2'h3
`define SLC_U_LINK_RESET 5'h19
`define SLC_U_UNN_ACK 5'h06
`define SLC_WIN_DEF 3'h4
`define SLC_WIN_MIN 3'h2
`define SLC_CAP_SREJ_BIT 0
`define SLC_SEQ_ZERO 3'h0
`define SLC_SEQ_ONE 3'h1
`define SLC_CLK_MHZ 250
`define SLC_ACK_US 5000
`define SLC_RETX_US 10000
`define SLC_CONN_US 5000
`define SLC_RREP_US 10000
`define SLC_TM_ACK 0
`define SLC_TM_RETX 1
`define SLC_TM_CONN 2
`define SLC_TM_RREP 3
`define SLC_TM_NUM 4
`define SLC_TM_W 24
`endif

// [inc/slc_pkg.sv]
// Types shared by the link controller files.
// Assumes slc_map.svh supplies the numeric constants.
package slc_pkg;
	typedef enum logic [1:0] {
		SLC_IDLE = 2'b00,
		SLC_SETUP = 2'b01,
		SLC_UP = 2'b10
	} slc_state_t;
	typedef logic [2:0] slc_seq_t;
endpackage

// [rtl/slc_timer.sv]
// One-shot down counter used for each protocol timeout.
// Assumes start and stop are single-cycle requests from the controller.
`timescale 1ns/100ps
`include "slc_map.svh"
module slc_timer (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Control
	input wire logic start_i,
	input wire logic stop_i,
	input wire logic [`SLC_TM_W-1:0] load_i,
	// Status
	output logic expire_o,
	output logic run_o
);
	logic [`SLC_TM_W-1:0] cnt_q, cnt_d;
	logic run_d, exp_d;

	always_comb begin
		cnt_d = cnt_q;
		run_d = run_o;
		exp_d = 1'b0;
		// Start wins so a restart never leaves the timer stopped
		if (start_i) begin
			cnt_d = load_i;
			run_d = 1'b1;
		end else if (stop_i) begin
			run_d = 1'b0;
		end else if (run_o) begin
			if (cnt_q == '0) begin
				exp_d = 1'b1;
				run_d = 1'b0;
			end else begin
				cnt_d = cnt_q - 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			cnt_q <= '0;
			run_o <= 1'b0;
			expire_o <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			run_o <= run_d;
			expire_o <= exp_d;
		end
	end
endmodule

// [rtl/slc_link_ctrl.sv]
// Sliding-window link controller: setup, acknowledgement, reject and flow stop.
// Assumes frames arrive checked and whole; frame payloads live in the upper layer,
// addressed by sequence number, so retransmission only replays numbers.
`timescale 1ns/100ps
`include "slc_map.svh"
// Operation
// - Window defaults to four, reducible only at setup, fixed until next reset.
// - Acknowledge within acknowledge time, five ms at window four, scaled with window.
// - Retransmit unacknowledged frames after retransmit time, at least ten ms.
// - Retry setup when no unnumbered acknowledgement within connection time.
// - Sequence counters wrap modulo eight; send counter steps per information frame.
// - Sent receive number acknowledges all frames numbered below it.
// - Oldest-unacknowledged counter marks start of outstanding frames up to send counter.
// - Window membership tests compare modulo eight with wrap handling.
// - Successful establishment clears send, receive and oldest counters.
// - Establishing endpoint starts by sending a link reset frame.
// - Unrecoverable error re-establishes link, discards buffers, reports reset upward.
// - Acceptable link reset draws unnumbered acknowledgement; its arrival establishes link.
// - Before establishment discard every frame except link reset and, during setup, unnumbered acknowledgement.
// - Crossed link resets both acknowledged establish link with default window.
// - Smaller window answers with own link reset; peer adopts it and acknowledges.
// - Acknowledge timer starts on first frame, sends receive-ready, stopped by information frames.
// - Sequence gap promptly triggers reject restarting at first missing frame.
// - Final burst frame acknowledged by receive-ready; lost final frame only by timer.
// - Receive-not-ready acknowledges like receive-ready and suspends peer information frames.
// - Resuming receive-ready repeats every five to twenty ms until information arrives.
// - Resuming receive-ready with no data pending answered by empty information frame.
// - With selective reject, one-ahead frame draws selective reject and is buffered.
// - Control byte coding for information, supervisory and unnumbered frames.
// - Supervisory types: ready 00, reject 01, not ready 10, selective 11.
// - Unnumbered modifiers: link reset 11001, acknowledgement 00110.
// - Link reset carries optional window two to four and capability byte.
module slc_link_ctrl #(
	parameter int ACK_CYC = `SLC_ACK_US * `SLC_CLK_MHZ,
	parameter int RETX_CYC = `SLC_RETX_US * `SLC_CLK_MHZ,
	parameter int CONN_CYC = `SLC_CONN_US * `SLC_CLK_MHZ,
	parameter int RREP_CYC = `SLC_RREP_US * `SLC_CLK_MHZ
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Upper layer control
	input wire logic connect_i,
	input wire logic error_i,
	input wire logic busy_i,
	input wire logic send_req_i,
	input wire logic [7:0] local_win_i,
	input wire logic local_srej_i,
	// Upper layer status
	output logic link_up_o,
	output logic link_reset_o,
	output logic deliver_o,
	output logic [2:0] deliver_seq_o,
	// Received frames
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_ctrl_i,
	input wire logic rx_win_vld_i,
	input wire logic [7:0] rx_win_i,
	input wire logic rx_cap_vld_i,
	input wire logic [7:0] rx_cap_i,
	// Transmitted frames
	input wire logic tx_ready_i,
	output logic tx_valid_o,
	output logic [7:0] tx_ctrl_o,
	output logic [7:0] tx_win_o,
	output logic [7:0] tx_cap_o,
	output logic [2:0] tx_seq_o,
	output logic tx_new_o,
	output logic tx_empty_o
);
	function automatic logic in_win(input slc_pkg::slc_seq_t x, input slc_pkg::slc_seq_t y,
		input slc_pkg::slc_seq_t z);
		if (x <= z) begin
			in_win = (x <= y) && (y < z);
		end else begin
			in_win = (y >= x) || (y < z);
		end
	endfunction

	function automatic logic [2:0] clamp_win(input logic [7:0] w);
		if (w > 8'(`SLC_WIN_DEF)) begin
			clamp_win = `SLC_WIN_DEF;
		end else if (w < 8'(`SLC_WIN_MIN)) begin
			clamp_win = `SLC_WIN_MIN;
		end else begin
			clamp_win = w[2:0];
		end
	endfunction

	slc_pkg::slc_state_t state_q, state_d;
	slc_pkg::slc_seq_t send_q, send_d, recv_q, recv_d, oldest_q, oldest_d, top_q, top_d;
	slc_pkg::slc_seq_t held_q, held_d;
	logic [2:0] win_q, win_d;
	logic srej_en_q, srej_en_d, held_vld_q, held_vld_d, flush_q, flush_d;
	logic link_reset_frame_pend_q, link_reset_frame_pend_d, ua_pend_q, ua_pend_d, rej_pend_q, rej_pend_d;
	logic rej_sent_q, rej_sent_d, srej_pend_q, srej_pend_d, rr_pend_q, rr_pend_d;
	logic rrep_on_q, rrep_on_d, peer_busy_q, peer_busy_d, empty_pend_q, empty_pend_d;
	logic busy_q, up_d, lreset_d, deliver_d, est;
	logic [2:0] dseq_d, tseq_d;
	logic [7:0] tctrl_d, twin_d, tcap_d;
	logic tvalid_d, tnew_d, tempty_d, ld_i, ld_new, tx_free;
	logic [`SLC_TM_NUM-1:0] tm_start, tm_stop, tm_exp, tm_run;
	logic [`SLC_TM_W-1:0] tm_load [`SLC_TM_NUM];
	logic [2:0] rx_nr, rx_ns, offer;
	logic rx_i, rx_s, rx_u, nr_ok;

	assign rx_nr = rx_ctrl_i[2:0];
	assign rx_ns = rx_ctrl_i[5:3];
	assign rx_i = rx_valid_i && (rx_ctrl_i[7:6] == `SLC_INFO_TAG);
	assign rx_s = rx_valid_i && (rx_ctrl_i[7:5] == `SLC_SUP_TAG);
	assign rx_u = rx_valid_i && (rx_ctrl_i[7:5] == `SLC_UNN_TAG);
	assign offer = rx_win_vld_i ? clamp_win(rx_win_i) : `SLC_WIN_DEF;
	assign nr_ok = in_win(oldest_q, rx_nr, 3'(top_q + `SLC_SEQ_ONE));
	assign tx_free = !tx_valid_o || tx_ready_i;
	// Acknowledge time scales with the negotiated window
	assign tm_load[`SLC_TM_ACK] = `SLC_TM_W'(ACK_CYC / `SLC_WIN_DEF) * `SLC_TM_W'(win_q);
	assign tm_load[`SLC_TM_RETX] = `SLC_TM_W'(RETX_CYC);
	assign tm_load[`SLC_TM_CONN] = `SLC_TM_W'(CONN_CYC);
	assign tm_load[`SLC_TM_RREP] = `SLC_TM_W'(RREP_CYC);

	generate
		for (genvar g = 0; g < `SLC_TM_NUM; g++) begin : g_tm
			slc_timer u_tm (
				.core_clk_i(core_clk_i),
				.srst_i(srst_i),
				.start_i(tm_start[g]),
				.stop_i(tm_stop[g]),
				.load_i(tm_load[g]),
				.expire_o(tm_exp[g]),
				.run_o(tm_run[g])
			);
		end
	endgenerate

	always_comb begin
		state_d = state_q;
		send_d = send_q;
		recv_d = recv_q;
		oldest_d = oldest_q;
		top_d = top_q;
		held_d = held_q;
		win_d = win_q;
		srej_en_d = srej_en_q;
		held_vld_d = held_vld_q;
		flush_d = 1'b0;
		link_reset_frame_pend_d = link_reset_frame_pend_q;
		ua_pend_d = ua_pend_q;
		rej_pend_d = rej_pend_q;
		rej_sent_d = rej_sent_q;
		srej_pend_d = srej_pend_q;
		rr_pend_d = rr_pend_q;
		rrep_on_d = rrep_on_q;
		peer_busy_d = peer_busy_q;
		empty_pend_d = empty_pend_q;
		up_d = link_up_o;
		lreset_d = 1'b0;
		deliver_d = 1'b0;
		dseq_d = deliver_seq_o;
		tvalid_d = tx_valid_o && !tx_ready_i;
		tctrl_d = tx_ctrl_o;
		twin_d = tx_win_o;
		tcap_d = tx_cap_o;
		tseq_d = tx_seq_o;
		tnew_d = tx_new_o;
		tempty_d = tx_empty_o;
		tm_start = '0;
		tm_stop = '0;
		est = 1'b0;
		ld_i = 1'b0;
		ld_new = 1'b0;
		// Responder is up once its acknowledgement has left
		if (tx_valid_o && tx_ready_i && state_q == slc_pkg::SLC_SETUP &&
			tx_ctrl_o == {`SLC_UNN_TAG, `SLC_U_UNN_ACK}) begin
			est = 1'b1;
		end
		if (flush_q) begin
			deliver_d = 1'b1;
			dseq_d = held_q;
			recv_d = 3'(held_q + `SLC_SEQ_ONE);
		end
		if (rx_u && rx_ctrl_i[4:0] == `SLC_U_LINK_RESET) begin
			if (state_q == slc_pkg::SLC_UP) begin
				lreset_d = 1'b1;
			end
			state_d = slc_pkg::SLC_SETUP;
			up_d = 1'b0;
			if (offer > clamp_win(local_win_i)) begin
				link_reset_frame_pend_d = 1'b1;
			end else begin
				win_d = offer;
				srej_en_d = local_srej_i && rx_cap_vld_i && rx_cap_i[`SLC_CAP_SREJ_BIT];
				ua_pend_d = 1'b1;
			end
		end else if (rx_u && rx_ctrl_i[4:0] == `SLC_U_UNN_ACK && state_q == slc_pkg::SLC_SETUP) begin
			est = !ua_pend_q;
		end else if (state_q == slc_pkg::SLC_UP) begin
			// Frames other than link reset, and unnumbered acknowledgement during setup, are ignored until the link is up
			if ((rx_i || rx_s) && nr_ok) begin
				oldest_d = rx_nr;
				if (rx_nr != oldest_q) begin
					tm_start[`SLC_TM_RETX] = (rx_nr != top_q);
					tm_stop[`SLC_TM_RETX] = (rx_nr == top_q);
				end
			end
			if (rx_i) begin
				rrep_on_d = 1'b0;
				if (rx_ns == recv_q) begin
					deliver_d = 1'b1;
					dseq_d = rx_ns;
					recv_d = 3'(recv_q + `SLC_SEQ_ONE);
					rej_sent_d = 1'b0;
					tm_start[`SLC_TM_ACK] = !tm_run[`SLC_TM_ACK];
					if (held_vld_q && held_q == 3'(recv_q + `SLC_SEQ_ONE)) begin
						flush_d = 1'b1;
						held_vld_d = 1'b0;
					end
				end else if (srej_en_q && !held_vld_q && rx_ns == 3'(recv_q + `SLC_SEQ_ONE)) begin
					srej_pend_d = 1'b1;
					held_vld_d = 1'b1;
					held_d = rx_ns;
				end else if (!rej_sent_q && !(held_vld_q && rx_ns == held_q)) begin
					rej_pend_d = 1'b1;
					rej_sent_d = 1'b1;
				end
			end
			if (rx_s) begin
				unique case (rx_ctrl_i[4:3])
					`SLC_S_RR: begin
						peer_busy_d = 1'b0;
						empty_pend_d = peer_busy_q && !send_req_i;
					end
					`SLC_S_REJ: send_d = rx_nr;
					`SLC_S_RNR: peer_busy_d = 1'b1;
					`SLC_S_SREJ: send_d = rx_nr;
				endcase
			end
			if (tm_exp[`SLC_TM_RETX] && oldest_q != top_q) begin
				send_d = oldest_q;
				tm_start[`SLC_TM_RETX] = 1'b1;
			end
			if (tm_exp[`SLC_TM_ACK]) begin
				rr_pend_d = 1'b1;
			end
			if (busy_q && !busy_i) begin
				rr_pend_d = 1'b1;
				rrep_on_d = 1'b1;
				tm_start[`SLC_TM_RREP] = 1'b1;
			end
			if (tm_exp[`SLC_TM_RREP] && rrep_on_q) begin
				rr_pend_d = 1'b1;
				tm_start[`SLC_TM_RREP] = 1'b1;
			end
		end
		if (tm_exp[`SLC_TM_CONN] && state_q == slc_pkg::SLC_SETUP && !est) begin
			link_reset_frame_pend_d = 1'b1;
		end
		if (connect_i || error_i) begin
			lreset_d = link_up_o;
			state_d = slc_pkg::SLC_SETUP;
			up_d = 1'b0;
			link_reset_frame_pend_d = 1'b1;
			ua_pend_d = 1'b0;
			est = 1'b0;
		end
		if (est) begin
			state_d = slc_pkg::SLC_UP;
			up_d = 1'b1;
			send_d = `SLC_SEQ_ZERO;
			recv_d = `SLC_SEQ_ZERO;
			oldest_d = `SLC_SEQ_ZERO;
			top_d = `SLC_SEQ_ZERO;
			tm_stop = '1;
		end
		if (est || state_d != slc_pkg::SLC_UP) begin
			// Buffered and pending traffic dies with the session
			held_vld_d = 1'b0;
			flush_d = 1'b0;
			rej_pend_d = 1'b0;
			rej_sent_d = 1'b0;
			srej_pend_d = 1'b0;
			rr_pend_d = 1'b0;
			rrep_on_d = 1'b0;
			peer_busy_d = 1'b0;
			empty_pend_d = 1'b0;
		end
		if (tx_free) begin
			tvalid_d = 1'b1;
			tseq_d = send_d;
			tnew_d = 1'b0;
			tempty_d = 1'b0;
			if (link_reset_frame_pend_d) begin
				link_reset_frame_pend_d = 1'b0;
				win_d = clamp_win(local_win_i);
				srej_en_d = local_srej_i;
				tctrl_d = {`SLC_UNN_TAG, `SLC_U_LINK_RESET};
				twin_d = 8'(clamp_win(local_win_i));
				tcap_d = 8'(local_srej_i);
				tm_start[`SLC_TM_CONN] = 1'b1;
			end else if (ua_pend_d) begin
				ua_pend_d = 1'b0;
				tctrl_d = {`SLC_UNN_TAG, `SLC_U_UNN_ACK};
			end else if (state_d != slc_pkg::SLC_UP) begin
				tvalid_d = 1'b0;
			end else if (srej_pend_d) begin
				srej_pend_d = 1'b0;
				tctrl_d = {`SLC_SUP_TAG, `SLC_S_SREJ, recv_d};
			end else if (rej_pend_d) begin
				rej_pend_d = 1'b0;
				tctrl_d = {`SLC_SUP_TAG, `SLC_S_REJ, recv_d};
			end else if (rr_pend_d) begin
				rr_pend_d = 1'b0;
				tctrl_d = {`SLC_SUP_TAG, busy_i ? `SLC_S_RNR : `SLC_S_RR, recv_d};
				tm_stop[`SLC_TM_ACK] = 1'b1;
			end else if (!peer_busy_d && (send_d != top_d ||
				((send_req_i || empty_pend_d) && 3'(top_d - oldest_d) < win_q))) begin
				ld_i = 1'b1;
				ld_new = (send_d == top_d);
				tnew_d = ld_new;
				tempty_d = ld_new && !send_req_i;
				empty_pend_d = empty_pend_d && !ld_new;
				tctrl_d = {`SLC_INFO_TAG, send_d, recv_d};
				send_d = 3'(send_d + `SLC_SEQ_ONE);
				top_d = ld_new ? send_d : top_d;
				tm_stop[`SLC_TM_ACK] = 1'b1;
				// Keep a restart raised by an acknowledgement this cycle, and turn its stop into a restart
				tm_start[`SLC_TM_RETX] = tm_start[`SLC_TM_RETX] || tm_stop[`SLC_TM_RETX] ||
					!tm_run[`SLC_TM_RETX];
			end else begin
				tvalid_d = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state_q <= slc_pkg::SLC_IDLE;
			send_q <= `SLC_SEQ_ZERO;
			recv_q <= `SLC_SEQ_ZERO;
			oldest_q <= `SLC_SEQ_ZERO;
			top_q <= `SLC_SEQ_ZERO;
			held_q <= `SLC_SEQ_ZERO;
			win_q <= `SLC_WIN_DEF;
			{srej_en_q, held_vld_q, flush_q, link_reset_frame_pend_q, ua_pend_q} <= '0;
			{rej_pend_q, rej_sent_q, srej_pend_q, rr_pend_q, rrep_on_q} <= '0;
			{peer_busy_q, empty_pend_q, busy_q} <= '0;
			{link_up_o, link_reset_o, deliver_o, tx_valid_o, tx_new_o, tx_empty_o} <= '0;
			deliver_seq_o <= `SLC_SEQ_ZERO;
			tx_seq_o <= `SLC_SEQ_ZERO;
			{tx_ctrl_o, tx_win_o, tx_cap_o} <= '0;
		end else begin
			state_q <= state_d;
			send_q <= send_d;
			recv_q <= recv_d;
			oldest_q <= oldest_d;
			top_q <= top_d;
			held_q <= held_d;
			win_q <= win_d;
			{srej_en_q, held_vld_q, flush_q, link_reset_frame_pend_q, ua_pend_q} <=
				{srej_en_d, held_vld_d, flush_d, link_reset_frame_pend_d, ua_pend_d};
			{rej_pend_q, rej_sent_q, srej_pend_q, rr_pend_q, rrep_on_q} <=
				{rej_pend_d, rej_sent_d, srej_pend_d, rr_pend_d, rrep_on_d};
			{peer_busy_q, empty_pend_q, busy_q} <= {peer_busy_d, empty_pend_d, busy_i};
			{link_up_o, link_reset_o, deliver_o} <= {up_d, lreset_d, deliver_d};
			{tx_valid_o, tx_new_o, tx_empty_o} <= {tvalid_d, tnew_d, tempty_d};
			deliver_seq_o <= dseq_d;
			tx_seq_o <= tseq_d;
			{tx_ctrl_o, tx_win_o, tx_cap_o} <= {tctrl_d, twin_d, tcap_d};
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	a_win_range: assert property (link_up_o |-> win_q >= `SLC_WIN_MIN && win_q <= `SLC_WIN_DEF)
		else $error("window outside two to four");
	a_send_step: assert property (ld_i |=> send_q == 3'(tx_seq_o + `SLC_SEQ_ONE))
		else $error("send counter did not step");
	a_est_clear: assert property ($rose(link_up_o) |-> (recv_q | oldest_q) == '0 &&
		(send_q == '0 || (tx_valid_o && tx_new_o && tx_ctrl_o[5:3] == '0 &&
		send_q == `SLC_SEQ_ONE)))
		else $error("counters not cleared on setup");
	a_reset_first: assert property (state_q == slc_pkg::SLC_IDLE && connect_i && !tx_valid_o
		|=> tx_valid_o && tx_ctrl_o == {`SLC_UNN_TAG, `SLC_U_LINK_RESET})
		else $error("setup did not open with link reset");
	a_drop_early: assert property (state_q != slc_pkg::SLC_UP |=> !deliver_o)
		else $error("frame delivered before setup");
	a_win_limit: assert property (link_up_o |-> 3'(top_q - oldest_q) <= win_q)
		else $error("outstanding frames exceed window");
	a_peer_stop: assert property (peer_busy_q && !rx_s |-> !ld_i)
		else $error("information frame sent to stopped peer");
	a_gap_reject: assert property (state_q == slc_pkg::SLC_UP && rx_i && rx_ns != recv_q &&
		!srej_en_q && !rej_sent_q && !connect_i && !error_i && !rx_u
		|=> rej_pend_q || (tx_valid_o && tx_ctrl_o[7:3] == {`SLC_SUP_TAG, `SLC_S_REJ}))
		else $error("gap did not raise reject");
	a_ack_start: assert property (state_q == slc_pkg::SLC_UP && rx_i && rx_ns == recv_q &&
		!tm_run[`SLC_TM_ACK] && !tm_stop[`SLC_TM_ACK] && !est |=> tm_run[`SLC_TM_ACK])
		else $error("acknowledge timer not started");
	c_link_up: cover property ($rose(link_up_o));
	c_reject: cover property (tx_valid_o && tx_ctrl_o[7:3] == {`SLC_SUP_TAG, `SLC_S_REJ});
	c_not_ready: cover property (tx_valid_o && tx_ctrl_o[7:3] == {`SLC_SUP_TAG, `SLC_S_RNR});
	c_held: cover property (flush_q);
endmodule

// [verif/slc_peer.sv]
// Peer endpoint model: takes frames with random stalls, sends frames on request.
// Assumes the bench seeds $urandom and calls send from its own sequence.
`timescale 1ns/100ps
module slc_peer (
	// Clock
	input wire logic core_clk_i,
	// Frames from the controller
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_ctrl_i,
	input wire logic [7:0] tx_win_i,
	input wire logic [2:0] tx_seq_i,
	input wire logic tx_new_i,
	input wire logic tx_empty_i,
	// Frames to the controller
	output logic tx_ready_o,
	output logic rx_valid_o,
	output logic [7:0] rx_ctrl_o,
	output logic rx_win_vld_o,
	output logic [7:0] rx_win_o
);
	logic [20:0] log_q[$];
	initial begin
		tx_ready_o = 1'b0;
		rx_valid_o = 1'b0;
		rx_ctrl_o = 8'h00;
		rx_win_vld_o = 1'b0;
		rx_win_o = 8'h00;
	end
	// Stall one cycle in four so held frames get exercised
	always @(negedge core_clk_i) begin
		tx_ready_o <= ($urandom_range(0, 3) != 0);
	end
	always @(posedge core_clk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			log_q.push_back({tx_win_i, tx_empty_i, tx_new_i, tx_seq_i, tx_ctrl_i});
		end
	end
	// One checked frame per call; a zero window byte means absent
	task automatic send(input logic [7:0] c, input logic [7:0] wb);
		@(negedge core_clk_i);
		rx_valid_o = 1'b1;
		rx_ctrl_o = c;
		rx_win_vld_o = (wb != 8'h00);
		rx_win_o = wb;
		@(negedge core_clk_i);
		rx_valid_o = 1'b0;
		rx_win_vld_o = 1'b0;
		// Released lines show junk, not the last byte
		rx_ctrl_o = ~c;
		rx_win_o = ~wb;
	endtask
endmodule

// [verif/slc_link_ctrl_bench.sv]
// Bench for the link controller against one peer model.
// Assumes shortened timer parameters; expectations derive from them.
`timescale 1ns/100ps
module slc_link_ctrl_bench;
	localparam int ACK = 400;
	localparam int RETX = 1000;
	localparam int CONN = 400;
	localparam int RREP = 800;
	logic core_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic connect_i = 1'b0;
	logic send_req_i = 1'b0;
	logic busy_i = 1'b0;
	logic [7:0] local_win_i = 8'h04;
	logic link_up_o, link_reset_o, deliver_o, tx_valid_o, tx_ready_i, rx_valid_i;
	logic rx_win_vld_i, tx_new_o, tx_empty_o;
	logic [2:0] deliver_seq_o, tx_seq_o;
	logic [7:0] rx_ctrl_i, rx_win_i, tx_ctrl_o, tx_win_o, tx_cap_o;
	int fail_count = 0;
	int n_checks = 0;
	int resets = 0;
	int w, n, cyc;
	logic [2:0] dq[$];
	logic [20:0] f;
	always #2 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		if (deliver_o === 1'b1) dq.push_back(deliver_seq_o);
		if (link_reset_o === 1'b1) resets++;
	end
	slc_link_ctrl #(.ACK_CYC(ACK), .RETX_CYC(RETX), .CONN_CYC(CONN), .RREP_CYC(RREP)) uut (
		.core_clk_i(core_clk_i), .srst_i(srst_i), .connect_i(connect_i), .error_i(1'b0),
		.busy_i(busy_i), .send_req_i(send_req_i), .local_win_i(local_win_i),
		.local_srej_i(1'b0), .link_up_o(link_up_o), .link_reset_o(link_reset_o),
		.deliver_o(deliver_o), .deliver_seq_o(deliver_seq_o), .rx_valid_i(rx_valid_i),
		.rx_ctrl_i(rx_ctrl_i), .rx_win_vld_i(rx_win_vld_i), .rx_win_i(rx_win_i),
		.rx_cap_vld_i(1'b0), .rx_cap_i(8'h00), .tx_ready_i(tx_ready_i),
		.tx_valid_o(tx_valid_o), .tx_ctrl_o(tx_ctrl_o), .tx_win_o(tx_win_o),
		.tx_cap_o(tx_cap_o), .tx_seq_o(tx_seq_o), .tx_new_o(tx_new_o), .tx_empty_o(tx_empty_o));
	slc_peer peer (
		.core_clk_i(core_clk_i), .tx_valid_i(tx_valid_o), .tx_ctrl_i(tx_ctrl_o),
		.tx_win_i(tx_win_o), .tx_seq_i(tx_seq_o), .tx_new_i(tx_new_o), .tx_empty_i(tx_empty_o),
		.tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i), .rx_ctrl_o(rx_ctrl_i),
		.rx_win_vld_o(rx_win_vld_i), .rx_win_o(rx_win_i));
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Next accepted frame, bounded wait
	task automatic next_tx(input int bound, output int c);
		c = 0;
		while (peer.log_q.size() == 0) begin
			@(negedge core_clk_i);
			c++;
			if (c > bound) begin
				check("tx frame arrival", 8'h01, 8'h00);
				summarize();
			end
		end
		f = peer.log_q.pop_front();
	endtask
	task automatic expect_ctrl(input string what, input logic [7:0] exp, input int bound);
		next_tx(bound, cyc);
		check(what, exp, f[7:0]);
	endtask
	initial begin
		n = $urandom(4);
		repeat (12) @(negedge core_clk_i);
		srst_i = 1'b0;
		check("link up after reset", 8'h00, {7'h00, link_up_o});
		check("tx valid after reset", 8'h00, {7'h00, tx_valid_o});
		peer.send(8'h80, 8'h00);
		repeat (10) @(negedge core_clk_i);
		check("delivered before setup", 8'h00, 8'(dq.size()));
		check("tx before setup", 8'h00, 8'(peer.log_q.size()));
		// Random own window; first reset left unanswered
		local_win_i = 8'($urandom_range(0, 7));
		w = (local_win_i < 2) ? 2 : (local_win_i > 4) ? 4 : int'(local_win_i);
		connect_i = 1'b1;
		@(negedge core_clk_i);
		connect_i = 1'b0;
		expect_ctrl("first link reset", 8'hF9, 20);
		check("offered window", 8'(w), f[20:13]);
		check("offered capability", 8'h00, tx_cap_o);
		next_tx(CONN + 50, cyc);
		check("retried link reset", 8'hF9, f[7:0]);
		check("retry not early", 8'h01, 8'(cyc > CONN - 20));
		peer.send(8'hE6, 8'h00);
		repeat (4) @(negedge core_clk_i);
		check("link up after ack", 8'h01, {7'h00, link_up_o});
		// Receive a burst, acknowledged by timer
		n = $urandom_range(1, w);
		for (int i = 0; i < n; i++) peer.send(8'h80 | 8'(i << 3), 8'h00);
		next_tx(ACK + 50, cyc);
		check("timed ready", 8'hC0 | 8'(n), f[7:0]);
		check("ack timer span", 8'h01,
			8'(cyc >= ACK * w / 4 - 2 * n - 12 && cyc <= ACK * w / 4 + 12));
		check("deliveries", 8'(n), 8'(dq.size()));
		for (int i = 0; i < n; i++) check("delivered number", 8'(i), 8'(dq.pop_front()));
		// Gap, then refill
		peer.send(8'h80 | 8'((n + 1) << 3), 8'h00);
		expect_ctrl("reject", 8'hC8 | 8'(n), 20);
		peer.send(8'h80 | 8'(n << 3), 8'h00);
		peer.send(8'h80 | 8'((n + 1) << 3), 8'h00);
		expect_ctrl("ready after refill", 8'hC0 | 8'(n + 2), ACK + 50);
		check("refill deliveries", 8'h02, 8'(dq.size()));
		dq.delete();
		// Sending up to the window
		send_req_i = 1'b1;
		for (int i = 0; i < w; i++) expect_ctrl("new info", 8'h80 | 8'(i << 3) | 8'(n + 2), 20);
		repeat (50) @(negedge core_clk_i);
		check("window stop", 8'h00, 8'(peer.log_q.size()));
		peer.send(8'hC2, 8'h00);
		expect_ctrl("after ack", 8'h80 | 8'(w << 3) | 8'(n + 2), 20);
		expect_ctrl("after ack", 8'h80 | 8'((w + 1) << 3) | 8'(n + 2), 20);
		send_req_i = 1'b0;
		next_tx(RETX + 100, cyc);
		check("retransmit oldest", 8'h80 | 8'(2 << 3) | 8'(n + 2), f[7:0]);
		check("retransmit old data", 8'h00, {7'h00, f[11]});
		check("retransmit number", 8'h02, 8'(f[10:8]));
		check("retransmit not early", 8'h01, 8'(cyc > RETX - 50));
		repeat (40) @(negedge core_clk_i);
		peer.log_q.delete();
		peer.send(8'hC0 | 8'(w + 2), 8'h00);
		// Flow stop and resume
		peer.send(8'hD0 | 8'(w + 2), 8'h00);
		send_req_i = 1'b1;
		repeat (100) @(negedge core_clk_i);
		check("halted by not ready", 8'h00, 8'(peer.log_q.size()));
		send_req_i = 1'b0;
		peer.send(8'hC0 | 8'(w + 2), 8'h00);
		expect_ctrl("empty info", 8'h80 | 8'((w + 2) << 3) | 8'(n + 2), 20);
		check("empty flag", 8'h01, {7'h00, f[12]});
		peer.send(8'hC0 | 8'(w + 3), 8'h00);
		// Peer resets a live link, offering the default window
		peer.send(8'hF9, 8'h00);
		next_tx(20, cyc);
		if (w < 4) begin
			check("own smaller reset", 8'hF9, f[7:0]);
			check("smaller window", 8'(w), f[20:13]);
			peer.send(8'hE6, 8'h00);
		end else begin
			check("reset answered", 8'hE6, f[7:0]);
		end
		repeat (6) @(negedge core_clk_i);
		check("torn down once", 8'h01, 8'(resets));
		check("up again", 8'h01, {7'h00, link_up_o});
		send_req_i = 1'b1;
		expect_ctrl("fresh counters", 8'h80, 30);
		send_req_i = 1'b0;
		expect_ctrl("second fresh info", 8'h88, 20);
		// Local receiver busy: the timed acknowledgement goes out as not ready
		busy_i = 1'b1;
		peer.send(8'h82, 8'h00);
		expect_ctrl("busy acknowledge", 8'hD1, ACK + 50);
		busy_i = 1'b0;
		expect_ctrl("resuming ready", 8'hC1, 20);
		next_tx(RREP + 100, cyc);
		check("repeated ready", 8'hC1, f[7:0]);
		check("repeat not early", 8'h01, 8'(cyc > RREP - 100));
		peer.send(8'h8A, 8'h00);
		expect_ctrl("ready after resume", 8'hC2, ACK + 50);
		repeat (RREP + 100) @(negedge core_clk_i);
		check("repeat stopped", 8'h00, 8'(peer.log_q.size()));
		check("busy deliveries", 8'h02, 8'(dq.size()));
		summarize();
	end
endmodule
